// File: tlb_pkg.sv
// Package for the telemetry converter and low-side breaker control block
package tlb_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int  CLK_PERIOD_PS      = 4000;
    localparam int  FIRST_RESULT_US    = 3600;
    localparam int  REFRESH_US         = 1800;
    // Cycles per microsecond first, so the product stays inside an int
    localparam int  CYC_PER_US         = 1000000 / CLK_PERIOD_PS;
    localparam int  FIRST_CYC          = FIRST_RESULT_US * CYC_PER_US;
    localparam int  REFRESH_CYC        = REFRESH_US * CYC_PER_US;
    localparam int  FAULT_FILTER_CYC   = 250;
    localparam int  RESTART_CYC        = 250000;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] CFG_ADDR    = 8'h10;
    localparam logic [7:0] RESULT_ADDR = 8'h11;
    localparam logic [7:0] SRC_ADDR0   = 8'h20;

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int  SEL_LSB            = 0;
    localparam int  MODE_LSB           = 5;
    localparam int  GAIN_BIT           = 7;
    localparam int  FRESH_BIT          = 12;
    localparam logic [15:0] CFG_RESET  = 16'h0000;
    localparam int  NPORTS             = 5;

    // Converter input selection codes
    localparam logic [4:0] SEL_TEMP    = 5'h00;
    localparam logic [4:0] SEL_LOW_I0  = 5'h01;
    localparam logic [4:0] SEL_VIN     = 5'h08;
    localparam logic [4:0] SEL_VPORT0  = 5'h09;

    // Sampling modes
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_CONT   = 2'h2;

    typedef enum logic [1:0] {
        CV_IDLE,
        CV_FIRST,
        CV_REFRESH
    } tlb_conv_state_t;

    // Register access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } tlb_reg_req_t;

endpackage : tlb_pkg

// File: tlb_ctrl.sv
// Telemetry converter control and low-side breaker supervision
//
// Function
// - Turn the return switch gate fully on when the first port reaches idle.
// - Sense above threshold for filter time trips breaker, forces ports overload.
// - Ports 1,2 share one sense input, ports 3,4 another, port 0 own.
// - Deep-sleep return switch closed; trip or overcurrent opens, restart closes.
// - Hold all non-disabled ports overloaded while negative-voltage fault keeps breaker tripped.
// - Five-bit field selects temperature, low-side current, supply or port voltage.
// - Two-bit mode field enables single-shot or continuous conversion.
// - First result about 3.6 ms after start, then every 1.8 ms continuous.
// - Fresh-result flag sits at bit 12 above the twelve-bit result.
// - Temperature code is 2048 offset, four codes per kelvin.
// - Port source-current result refreshes every 1.8 ms, valid in power states.
// - Source-current code is offset binary around 2048, ten units per code.
// - Low-side current result is offset binary, 100 uV per code.
// - Voltage results choose high or low gain in continuous mode.
// - Port voltage is positive output minus negative output, differential.
`timescale 1ns/1ps
module tlb_ctrl
    import tlb_pkg::*;
#(
    parameter int FIRST_CYCLES   = FIRST_CYC,
    parameter int REFRESH_CYCLES = REFRESH_CYC,
    parameter int RESTART_CYCLES = RESTART_CYC
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset,
    // Register access
    input  wire tlb_reg_req_t             reg_req,
    output logic [15:0]                   reg_rdata,
    // Sampled converter core, one code per input selection
    input  wire logic [11:0]              conv_code,
    input  wire logic [NPORTS-1:0][11:0]  src_code,
    output logic [4:0]                    conv_mux_sel,
    output logic                          conv_high_gain,
    output logic                          conv_sample,
    // Port state from the port machines
    input  wire logic [NPORTS-1:0]        port_idle,
    input  wire logic [NPORTS-1:0]        port_disabled,
    input  wire logic [NPORTS-1:0]        port_powered,
    input  wire logic [NPORTS-1:0]        port_overcurrent,
    // Low-side comparators, one per sense input (pins)
    input  wire logic [2:0]               return_over_threshold,
    // Breaker and switch controls
    output logic                          return_switch_gate,
    output logic [NPORTS-1:0]             force_overload,
    output logic                          sleep_return_closed,
    output logic                          breaker_tripped
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [2:0] thr_s1_q, thr_s2_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            thr_s1_q <= '0;
            thr_s2_q <= '0;
        end else begin
            thr_s1_q <= return_over_threshold;
            thr_s2_q <= thr_s1_q;
        end
    end

    // ****************************************************************
    // Configuration register
    // ****************************************************************
    logic [15:0] cfg_q, cfg_d;
    logic        start;
    always_comb begin
        cfg_d = cfg_q;
        start = 1'b0;
        if (reg_req.wr && reg_req.addr == CFG_ADDR) begin
            cfg_d = reg_req.wdata;
            start = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) cfg_q <= CFG_RESET;
        else       cfg_q <= cfg_d;
    end

    logic [4:0] sel;
    logic [1:0] mode;
    assign sel  = cfg_q[SEL_LSB +: 5];
    assign mode = cfg_q[MODE_LSB +: 2];
    // Selection drives the analog mux; port voltage is differential
    assign conv_mux_sel   = sel;
    // Gain choice takes effect in continuous mode only
    assign conv_high_gain = cfg_q[GAIN_BIT] && (mode == MODE_CONT);

    // ****************************************************************
    // Shared converter sequencer
    // ****************************************************************
    tlb_conv_state_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic        done;
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        done = 1'b0;
        if (start) begin
            cnt_d = '0;
            st_d = (cfg_d[MODE_LSB +: 2] == MODE_SINGLE ||
                    cfg_d[MODE_LSB +: 2] == MODE_CONT) ? CV_FIRST : CV_IDLE;
        end else begin
            unique case (st_q)
                CV_IDLE: cnt_d = '0;
                CV_FIRST: begin
                    cnt_d = cnt_q + 32'h0000_0001;
                    if (cnt_q == 32'(FIRST_CYCLES - 1)) begin
                        done = 1'b1;
                        cnt_d = '0;
                        // Single shot stops after one result
                        st_d = (mode == MODE_CONT) ? CV_REFRESH : CV_IDLE;
                    end
                end
                CV_REFRESH: begin
                    cnt_d = cnt_q + 32'h0000_0001;
                    if (cnt_q == 32'(REFRESH_CYCLES - 1)) begin
                        done = 1'b1;
                        cnt_d = '0;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q  <= CV_IDLE;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end
    assign conv_sample = done;

    // ****************************************************************
    // Result and fresh flag
    // ****************************************************************
    // Code is stored raw; offset-binary 2048 scalings apply
    logic [11:0] res_q, res_d;
    logic        fresh_q, fresh_d;
    logic        rd_result;
    assign rd_result = reg_req.rd && reg_req.addr == RESULT_ADDR;
    always_comb begin
        res_d = res_q;
        fresh_d = fresh_q;
        if (start) fresh_d = 1'b0;            // Old result marked stale, code kept
        else if (rd_result) fresh_d = 1'b0;
        if (done) begin                       // Set wins over clear
            res_d = conv_code;
            fresh_d = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            res_q   <= '0;
            fresh_q <= 1'b0;
        end else begin
            res_q   <= res_d;
            fresh_q <= fresh_d;
        end
    end

    // ****************************************************************
    // Per-port source-current results
    // ****************************************************************
    logic [31:0] sc_cnt_q, sc_cnt_d;
    logic        sc_tick;
    logic [NPORTS-1:0][11:0] src_q, src_d;
    always_comb begin
        sc_tick = (sc_cnt_q == 32'(REFRESH_CYCLES - 1));
        sc_cnt_d = sc_tick ? '0 : sc_cnt_q + 32'h0000_0001;
    end
    generate
        for (genvar p = 0; p < NPORTS; p++) begin : g_src
            // Refresh only while the port is powered
            always_comb begin
                src_d[p] = src_q[p];
                if (sc_tick && port_powered[p]) src_d[p] = src_code[p];
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (reset) begin
            sc_cnt_q <= '0;
            src_q    <= '0;
        end else begin
            sc_cnt_q <= sc_cnt_d;
            src_q    <= src_d;
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        reg_rdata = 16'h0000;
        if (reg_req.addr == CFG_ADDR)
            reg_rdata = cfg_q;
        else if (reg_req.addr == RESULT_ADDR)
            reg_rdata = {3'b000, fresh_q, res_q};
        else
            for (int i = 0; i < NPORTS; i++)
                if (reg_req.addr == SRC_ADDR0 + 8'(i))
                    reg_rdata = {4'h0, src_q[i]};
    end

    // ****************************************************************
    // Low-side breaker
    // ****************************************************************
    // Sense inputs: 0 for port 0, 1 for ports 1-2, 2 for ports 3-4
    logic [7:0] flt_q, flt_d;
    logic       trip_q, trip_d;
    logic       gate_q, gate_d;
    always_comb begin
        flt_d = (|thr_s2_q) ? flt_q + 8'h01 : 8'h00;
        trip_d = trip_q;
        if (|thr_s2_q && flt_q == 8'(FAULT_FILTER_CYC - 1)) begin
            trip_d = 1'b1;
            flt_d  = flt_q;
        end
        // Trip held while the fault persists
        if (trip_q && !(|thr_s2_q) && !(|port_idle) && gate_q == 1'b0)
            trip_d = 1'b0;
        gate_d = gate_q;
        if (|port_idle && !trip_q) gate_d = 1'b1;
        if (trip_q) gate_d = 1'b0;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            flt_q  <= '0;
            trip_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            flt_q  <= flt_d;
            trip_q <= trip_d;
            gate_q <= gate_d;
        end
    end
    assign return_switch_gate = gate_q;
    assign breaker_tripped    = trip_q;
    // Every port out of disabled goes to overload
    assign force_overload     = trip_q ? ~port_disabled : '0;

    // ****************************************************************
    // Deep-sleep return switch
    // ****************************************************************
    logic [31:0] rs_q, rs_d;
    logic        open_q, open_d;
    always_comb begin
        rs_d = rs_q;
        open_d = open_q;
        if (trip_q || |port_overcurrent) begin
            open_d = 1'b1;
            rs_d = '0;
        end else if (open_q) begin
            rs_d = rs_q + 32'h0000_0001;
            if (rs_q == 32'(RESTART_CYCLES - 1)) open_d = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            rs_q   <= '0;
            open_q <= 1'b0;
        end else begin
            rs_q   <= rs_d;
            open_q <= open_d;
        end
    end
    assign sleep_return_closed = !open_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence fault_run_s;
        (|thr_s2_q)[*8];
    endsequence
    gate_on_a: assert property (@(posedge clk) disable iff (reset)
        (|port_idle && !trip_q) |=> gate_q)
        else $error("gate not on after idle");
    trip_ovl_a: assert property (@(posedge clk) disable iff (reset)
        trip_q |-> (force_overload == ~port_disabled))
        else $error("overload not forced");
    trip_gate_a: assert property (@(posedge clk) disable iff (reset)
        trip_q |=> !gate_q)
        else $error("gate on while tripped");
    filt_a: assert property (@(posedge clk) disable iff (reset)
        (!trip_q && $rose(|thr_s2_q)) ##0 fault_run_s |-> !trip_q)
        else $error("trip before filter time");
    sleep_a: assert property (@(posedge clk) disable iff (reset)
        (trip_q || |port_overcurrent) |=> !sleep_return_closed)
        else $error("return switch not opened");
    fresh_a: assert property (@(posedge clk) disable iff (reset)
        done |=> fresh_q && res_q == $past(conv_code))
        else $error("result not captured");
    fresh_clr_a: assert property (@(posedge clk) disable iff (reset)
        (rd_result && !done && !start) |=> !fresh_q)
        else $error("fresh flag not cleared by read");
    single_a: assert property (@(posedge clk) disable iff (reset)
        (done && mode == MODE_SINGLE && !start) |=> st_q == CV_IDLE)
        else $error("single shot did not stop");
    first_a: assert property (@(posedge clk) disable iff (reset)
        (start && st_d == CV_FIRST) |=> !done [*8])
        else $error("result too early");
    gain_a: assert property (@(posedge clk) disable iff (reset)
        (mode != MODE_CONT) |-> !conv_high_gain)
        else $error("gain outside continuous mode");
    src_a: assert property (@(posedge clk) disable iff (reset)
        (sc_tick && port_powered[0]) |=> src_q[0] == $past(src_code[0]))
        else $error("source current not refreshed");

endmodule : tlb_ctrl

// File: tlb_conv_model.sv
// Converter core and port sense model facing the control block
`timescale 1ns/1ps
module tlb_conv_model
    import tlb_pkg::*;
(
    // Selection from the block
    input  wire logic [4:0]              sel,
    input  wire logic                    high_gain,
    // Codes back to the block
    output logic [11:0]                  code,
    output logic [NPORTS-1:0][11:0]      src
);
    // Code follows selection and gain; each source code carries its port number
    always_comb begin
        code = {4'h8, 2'b00, high_gain, sel};
        for (int p = 0; p < NPORTS; p++) begin
            src[p] = {4'hA, 3'h0, 5'(p)};
        end
    end
endmodule : tlb_conv_model

// File: test_tlb_ctrl.sv
// Self-checking bench for the converter control and breaker block
`timescale 1ns/1ps
module test_tlb_ctrl;
    import tlb_pkg::*;
    // ********
    // Setup
    // ********
    localparam int FC = 20;
    localparam int RC = 10;
    localparam int SC = 16;
    typedef struct packed {
        logic [4:0] sel;
        logic [1:0] mode;
        logic       gain;
        logic       exp_gain;
    } tlb_row_t;
    logic                    clk = 1'b0;
    logic                    reset = 1'b1;
    tlb_reg_req_t            reg_req = '0;
    logic [15:0]             reg_rdata;
    logic [11:0]             conv_code;
    logic [NPORTS-1:0][11:0] src_code;
    logic [4:0]              conv_mux_sel;
    logic                    conv_high_gain;
    logic                    conv_sample;
    logic [NPORTS-1:0]       port_idle = '0;
    logic [NPORTS-1:0]       port_disabled = 5'h04;
    logic [NPORTS-1:0]       port_powered = '1;
    logic [NPORTS-1:0]       port_overcurrent = '0;
    logic [2:0]              return_over_threshold = '0;
    logic                    return_switch_gate;
    logic [NPORTS-1:0]       force_overload;
    logic                    sleep_return_closed;
    logic                    breaker_tripped;
    int                      miscompares = 0;
    int                      n_tests = 0;
    int                      cnt;
    logic                    hg;
    tlb_row_t rows [4] = '{'{SEL_TEMP, MODE_SINGLE, 1'b0, 1'b0},
        '{SEL_LOW_I0 + 5'h02, MODE_SINGLE, 1'b1, 1'b0},
        '{SEL_VIN, MODE_CONT, 1'b1, 1'b1},
        '{SEL_VPORT0 + 5'h04, MODE_CONT, 1'b0, 1'b0}};

    // Clock
    always #2 clk = ~clk;

    tlb_ctrl #(.FIRST_CYCLES(FC), .REFRESH_CYCLES(RC),
        .RESTART_CYCLES(SC)) dut (
        .clk(clk), .reset(reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .conv_code(conv_code),
        .src_code(src_code), .conv_mux_sel(conv_mux_sel),
        .conv_high_gain(conv_high_gain), .conv_sample(conv_sample),
        .port_idle(port_idle), .port_disabled(port_disabled),
        .port_powered(port_powered),
        .port_overcurrent(port_overcurrent),
        .return_over_threshold(return_over_threshold),
        .return_switch_gate(return_switch_gate),
        .force_overload(force_overload),
        .sleep_return_closed(sleep_return_closed),
        .breaker_tripped(breaker_tripped));

    tlb_conv_model model (.sel(conv_mux_sel), .high_gain(conv_high_gain),
        .code(conv_code), .src(src_code));

    // ********
    // Tasks
    // ********
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        reg_req = '0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] m,
                      input logic [15:0] e);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        #1 chk(reg_rdata & m, e);
        @(negedge clk);
        reg_req = '0;
        @(negedge clk);
    endtask : rd

    // Counts cycles until a capture pulse, or up to the limit
    task automatic wait_sample(input int lim);
        cnt = 0;
        while (conv_sample !== 1'b1 && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
    endtask : wait_sample

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // Watchdog against a hang
    initial begin
        #80000;
        miscompares++;
        results();
    end

    // ********
    // Main sequence
    // ********
    initial begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        rd(CFG_ADDR, 16'hFFFF, CFG_RESET);
        chk(16'({return_switch_gate, breaker_tripped}), 16'h0000);
        chk(16'(sleep_return_closed), 16'h0001);
        chk(16'(force_overload), 16'h0000);
        // Table of converter selections and modes
        foreach (rows[i]) begin
            hg = rows[i].exp_gain;
            wr(CFG_ADDR, {8'h00, rows[i].gain, rows[i].mode, rows[i].sel});
            chk(16'(conv_mux_sel), 16'(rows[i].sel));
            chk(16'(conv_high_gain), 16'(hg));
            wait_sample(FC + 8);
            // Write task returns one cycle after the start edge
            chk(16'(cnt), 16'(FC - 2));
            @(negedge clk);
            rd(RESULT_ADDR, 16'h1FFF,
               {4'h1, 4'h8, 2'b00, hg, rows[i].sel});
            rd(RESULT_ADDR, 16'h1000, 16'h0000);
            rd(CFG_ADDR, 16'hFFFF,
               {8'h00, rows[i].gain, rows[i].mode, rows[i].sel});
        end
        // Continuous refresh period
        wait_sample(RC + 4);
        @(negedge clk);
        wait_sample(RC + 4);
        chk(16'(cnt), 16'(RC - 1));
        // Single shot stops after one capture
        wr(CFG_ADDR, {8'h00, 1'b0, MODE_SINGLE, SEL_TEMP});
        wait_sample(FC + 8);
        @(negedge clk);
        wait_sample(3 * RC);
        chk(16'(cnt), 16'(3 * RC));
        // Both off codes give no capture
        for (int m = 0; m < 4; m += 3) begin
            wr(CFG_ADDR, {8'h00, 1'b0, 2'(m), SEL_TEMP});
            wait_sample(FC + 8);
            chk(16'(cnt), 16'(FC + 8));
        end
        // Source current readback and unmapped read
        for (int p = 0; p < NPORTS; p++) begin
            rd(SRC_ADDR0 + 8'(p), 16'h0FFF, {4'hA, 3'h0, 5'(p)});
        end
        rd(8'h30, 16'hFFFF, 16'h0000);
        // Gate on at first idle, short pulse filtered
        port_idle = 5'h01;
        repeat (3) @(negedge clk);
        chk(16'(return_switch_gate), 16'h0001);
        return_over_threshold = 3'b010;
        repeat (100) @(negedge clk);
        return_over_threshold = 3'b000;
        repeat (5) @(negedge clk);
        chk(16'(breaker_tripped), 16'h0000);
        // Trip from each sense input, hold, clear and restart
        for (int s = 0; s < 3; s++) begin
            port_idle = 5'h01;
            repeat (3) @(negedge clk);
            return_over_threshold = 3'(1 << s);
            repeat (240) @(negedge clk);
            chk(16'(breaker_tripped), 16'h0000);
            repeat (20) @(negedge clk);
            chk(16'(breaker_tripped), 16'h0001);
            chk(16'(return_switch_gate), 16'h0000);
            chk(16'(sleep_return_closed), 16'h0000);
            repeat (30) @(negedge clk);
            chk(16'(force_overload), {11'h000, ~port_disabled});
            return_over_threshold = 3'b000;
            port_idle = 5'h00;
            repeat (5) @(negedge clk);
            chk(16'({breaker_tripped, sleep_return_closed}), 16'h0000);
            repeat (SC + 8) @(negedge clk);
            chk(16'(sleep_return_closed), 16'h0001);
        end
        // Overcurrent opens the return switch
        port_overcurrent = 5'h08;
        repeat (3) @(negedge clk);
        chk(16'(sleep_return_closed), 16'h0000);
        port_overcurrent = 5'h00;
        repeat (SC + 8) @(negedge clk);
        chk(16'(sleep_return_closed), 16'h0001);
        // Mid-run reset with a running converter and an open switch
        wr(CFG_ADDR, {8'h00, 1'b1, MODE_CONT, SEL_VIN});
        port_overcurrent = 5'h01;
        @(negedge clk);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        port_overcurrent = 5'h00;
        reset = 1'b0;
        chk(16'(conv_high_gain), 16'h0000);
        chk(16'({return_switch_gate, breaker_tripped}), 16'h0000);
        chk(16'(sleep_return_closed), 16'h0001);
        rd(RESULT_ADDR, 16'hFFFF, 16'h0000);
        rd(CFG_ADDR, 16'hFFFF, CFG_RESET);
        results();
    end
endmodule : test_tlb_ctrl
